// ===== logic/cctu_pkg.sv
// Constants, register map and types of the compare/capture timer unit
package cctu_pkg;
   // Machine cycle and divider figures
   localparam int unsigned CCTU_MC_CLOCKS = 12;
   localparam logic [3:0]  CCTU_MC_LAST   = 4'(CCTU_MC_CLOCKS - 1);
   localparam int unsigned CCTU_NUM_CC    = 5;   // Reload/compare plus four compare/capture
   localparam int unsigned CCTU_MAX_CM    = 8;
   localparam int unsigned CCTU_NUM_CAP   = CCTU_NUM_CC - 1;
   localparam logic [15:0] CCTU_CNT_MAX   = 16'hFFFF;
   localparam logic [3:0]  CCTU_ONE4      = 4'h1;
   localparam logic [7:0]  CCTU_ONES8     = 8'hFF;

   // Register byte addresses, one 32-bit word each
   localparam int unsigned CCTU_ADDR_W       = 8;
   localparam logic [7:0]  CCTU_ADDR_T2CTRL  = 8'h00;
   localparam logic [7:0]  CCTU_ADDR_T2CNT   = 8'h04;
   localparam logic [7:0]  CCTU_ADDR_CRC     = 8'h08;
   localparam logic [7:0]  CCTU_ADDR_CTCTRL  = 8'h0C;
   localparam logic [7:0]  CCTU_ADDR_CTCNT   = 8'h10;
   localparam logic [7:0]  CCTU_ADDR_CTREL   = 8'h14;
   localparam logic [7:0]  CCTU_ADDR_STATUS  = 8'h18;
   localparam logic [7:0]  CCTU_ADDR_CCMODE  = 8'h1C;
   localparam logic [7:0]  CCTU_ADDR_CC1     = 8'h20;
   localparam logic [7:0]  CCTU_ADDR_CMSEL   = 8'h30;
   localparam logic [7:0]  CCTU_ADDR_PORTCMP = 8'h34;
   localparam logic [7:0]  CCTU_ADDR_CMP2    = 8'h38;
   localparam logic [7:0]  CCTU_ADDR_SETCMP  = 8'h3C;
   localparam logic [7:0]  CCTU_ADDR_CLRCMP  = 8'h40;
   localparam logic [7:0]  CCTU_ADDR_PORT5   = 8'h44;
   localparam logic [7:0]  CCTU_ADDR_CM0     = 8'h48;
   localparam logic [7:0]  CCTU_REG_STRIDE   = 8'h04;

   // Field positions
   localparam int unsigned CCTU_STAT_T2OVF   = 0;
   localparam int unsigned CCTU_STAT_CTOVF   = 1;
   localparam int unsigned CCTU_STAT_CH0     = 2;
   localparam int unsigned CCTU_CMSEL_LSB    = 8;
   localparam int unsigned CCTU_CLEAR_MASK_REGISTER_LSB   = 8;
   localparam int unsigned CCTU_CMP2_EN_BIT  = 16;
   localparam int unsigned CCTU_CT_RUN_BIT   = 3;

   // Reset values
   localparam logic [7:0]  CCTU_PORT5_RST    = 8'hFF;

   // Timer 2 input modes and compare channel modes
   typedef enum logic [1:0] {T2_STOP, T2_TIMER, T2_GATED, T2_EVENT} cctu_t2mode_t;
   typedef enum logic [1:0] {CM_OFF, CM_MODE0, CM_MODE1, CM_CAPTURE} cctu_cmode_t;

   // Timer 2 control word
   typedef struct packed {
      logic         reloadMode1;
      logic         reloadEn;
      logic         presc24;
      cctu_t2mode_t mode;
   } cctu_t2ctrl_t;
endpackage : cctu_pkg

// ===== logic/cctu_compare_capture_timer.sv
// Compare/capture timer unit: timer 2, compare timer, compare channels, AHB-Lite slave
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Timer mode counts at osc/12 or osc/24
// - Gated mode counts only while gate high
// - Gate input sampled once per machine cycle
// - Event mode counts sampled falling edges
// - Reload mode 0: overflow sets flag, loads reload
// - Reload mode 1: trigger falling edge loads reload
// - Compare timer prescaler osc/2 to osc/256
// - Compare timer free-runs, reloads on overflow
// - Compare timer rollover sets its overflow flag
// - Channels compare value, act, flag match
// - Mode 0: high on match, low on overflow
// - Mode 0 ignores software port writes
// - Mode 1: writes go to shadow, moved on match
// - Mode 2 set match drives masked pins high
// - Mode 2 clear match drives masked pins low
// - Reload/compare and capture registers use timer 2
// - Each compare register picks timer 2 or compare timer
// - Machine cycle is twelve clock periods
module cctu_compare_capture_timer #(
   parameter int unsigned NUM_CM = 8
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   // Timer 2 pins
   input  wire logic                     timer2CountGatePin,
   input  wire logic                     reloadTriggerPin,
   input  wire logic [cctu_pkg::CCTU_NUM_CAP-1:0] capturePin,
   // Compare outputs and flags
   output logic [cctu_pkg::CCTU_NUM_CC+NUM_CM-1:0] compareOut,
   output logic [7:0]                    port5Out,
   output logic                          timer2OverflowFlag,
   output logic                          compareTimerOverflowFlag
);
   import cctu_pkg::*;

   localparam int unsigned NCH = CCTU_NUM_CC + NUM_CM;

   if (NUM_CM < 1 || NUM_CM > CCTU_MAX_CM) begin : g_bad_cm
      $error("NUM_CM must be 1 to 8");
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // Register state
   cctu_t2ctrl_t      t2Ctrl_reg;
   logic [15:0]       t2Count_reg, crc_reg, ctCount_reg, ctReload_reg, setCmp_reg, clrCmp_reg;
   logic [3:0]        ctCtrl_reg;
   logic [NUM_CM-1:0] cmEn_reg, cmSel_reg;
   logic [2*CCTU_NUM_CC-1:0] ccMode_reg;
   logic [15:0]       ccVal_reg [CCTU_NUM_CAP];
   logic [15:0]       cmVal_reg [NUM_CM];
   logic [NCH-1:0]    portShadow_reg;
   logic [7:0]        setMask_reg, clrMask_reg;
   logic              mode2En_reg;
   logic [NCH+1:0]    status_reg;
   // Bus state
   logic              pend_reg, pendWrite_reg;
   logic [7:0]        pAddr_reg;
   logic [31:0]       rdValue;
   logic              wrEn;

   // Address phase taken, answered after one wait state so hrdata is a flop
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg      <= 1'b0;
         pendWrite_reg <= 1'b0;
         pAddr_reg     <= 8'h00;
         hreadyout     <= 1'b1;
         hrdata        <= 32'h0000_0000;
         hresp         <= 1'b0;
      end else begin
         hresp <= 1'b0; // Always OKAY
         if (hsel && htrans[1] && hready) begin
            pend_reg      <= 1'b1;
            pendWrite_reg <= hwrite;
            pAddr_reg     <= {haddr[CCTU_ADDR_W-1:2], 2'b00};
            hreadyout     <= 1'b0;
         end else if (pend_reg) begin
            pend_reg  <= 1'b0;
            hreadyout <= 1'b1;
            if (!pendWrite_reg) begin
               hrdata <= rdValue;
            end
         end
      end
   end

   assign wrEn = pend_reg && pendWrite_reg;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdValue = 32'h0000_0000;
      unique case (pAddr_reg)
         CCTU_ADDR_T2CTRL:  rdValue = 32'(t2Ctrl_reg);
         CCTU_ADDR_T2CNT:   rdValue = 32'(t2Count_reg);
         CCTU_ADDR_CRC:     rdValue = 32'(crc_reg);
         CCTU_ADDR_CTCTRL:  rdValue = 32'(ctCtrl_reg);
         CCTU_ADDR_CTCNT:   rdValue = 32'(ctCount_reg);
         CCTU_ADDR_CTREL:   rdValue = 32'(ctReload_reg);
         CCTU_ADDR_STATUS:  rdValue = 32'(status_reg);
         CCTU_ADDR_CCMODE:  rdValue = 32'(ccMode_reg);
         CCTU_ADDR_CMSEL:   rdValue = 32'(cmEn_reg) | (32'(cmSel_reg) << CCTU_CMSEL_LSB);
         CCTU_ADDR_PORTCMP: rdValue = 32'(compareOut);
         CCTU_ADDR_CMP2:    rdValue = {15'h0000, mode2En_reg, clrMask_reg, setMask_reg};
         CCTU_ADDR_SETCMP:  rdValue = 32'(setCmp_reg);
         CCTU_ADDR_CLRCMP:  rdValue = 32'(clrCmp_reg);
         CCTU_ADDR_PORT5:   rdValue = 32'(port5Out);
         default:           rdValue = 32'h0000_0000;
      endcase
      for (int k = 0; k < CCTU_NUM_CAP; k++) begin
         if (pAddr_reg == CCTU_ADDR_CC1 + 8'(k) * CCTU_REG_STRIDE) begin
            rdValue = 32'(ccVal_reg[k]);
         end
      end
      for (int k = 0; k < NUM_CM; k++) begin
         if (pAddr_reg == CCTU_ADDR_CM0 + 8'(k) * CCTU_REG_STRIDE) begin
            rdValue = 32'(cmVal_reg[k]);
         end
      end
   end

   // Plain control registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t2Ctrl_reg     <= '0;
         crc_reg        <= 16'h0000;
         ctCtrl_reg     <= 4'h0;
         ctReload_reg   <= 16'h0000;
         ccMode_reg     <= '0;
         cmEn_reg       <= '0;
         cmSel_reg      <= '0;
         portShadow_reg <= '1;
         setMask_reg    <= 8'h00;
         clrMask_reg    <= 8'h00;
         mode2En_reg    <= 1'b0;
         setCmp_reg     <= 16'h0000;
         clrCmp_reg     <= 16'h0000;
         for (int k = 0; k < NUM_CM; k++) cmVal_reg[k] <= 16'h0000;
      end else if (wrEn) begin
         unique case (pAddr_reg)
            CCTU_ADDR_T2CTRL:  t2Ctrl_reg <= cctu_t2ctrl_t'(hwdata[$bits(cctu_t2ctrl_t)-1:0]);
            CCTU_ADDR_CRC:     crc_reg <= hwdata[15:0];
            CCTU_ADDR_CTCTRL:  ctCtrl_reg <= hwdata[3:0];
            CCTU_ADDR_CTREL:   ctReload_reg <= hwdata[15:0];
            CCTU_ADDR_CCMODE:  ccMode_reg <= hwdata[2*CCTU_NUM_CC-1:0];
            CCTU_ADDR_CMSEL: begin
               cmEn_reg  <= hwdata[NUM_CM-1:0];
               cmSel_reg <= hwdata[CCTU_CMSEL_LSB +: NUM_CM];
            end
            CCTU_ADDR_PORTCMP: portShadow_reg <= hwdata[NCH-1:0]; // Shadow always written
            CCTU_ADDR_CMP2: begin
               setMask_reg <= hwdata[7:0];
               clrMask_reg <= hwdata[CCTU_CLEAR_MASK_REGISTER_LSB +: 8];
               mode2En_reg <= hwdata[CCTU_CMP2_EN_BIT];
            end
            CCTU_ADDR_SETCMP:  setCmp_reg <= hwdata[15:0];
            CCTU_ADDR_CLRCMP:  clrCmp_reg <= hwdata[15:0];
            default: ;
         endcase
         for (int k = 0; k < NUM_CM; k++) begin
            if (pAddr_reg == CCTU_ADDR_CM0 + 8'(k) * CCTU_REG_STRIDE) cmVal_reg[k] <= hwdata[15:0];
         end
      end
   end

   // Machine cycle enable and input samplers, all stepped once per machine cycle
   logic [3:0]              mcDiv_reg;
   logic                    mcEn, half24_reg, gateSamp_reg, evSamp_reg, evPrev_reg;
   logic                    trigSamp_reg, trigPrev_reg;
   logic [CCTU_NUM_CAP-1:0] capSamp_reg, capPrev_reg;
   assign mcEn = (mcDiv_reg == CCTU_MC_LAST);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mcDiv_reg    <= 4'h0;
         half24_reg   <= 1'b0;
         gateSamp_reg <= 1'b0;
         evSamp_reg   <= 1'b0;
         evPrev_reg   <= 1'b0;
         trigSamp_reg <= 1'b0;
         trigPrev_reg <= 1'b0;
         capSamp_reg  <= '0;
         capPrev_reg  <= '0;
      end else begin
         mcDiv_reg <= mcEn ? 4'h0 : mcDiv_reg + CCTU_ONE4;
         if (mcEn) begin
            half24_reg   <= !half24_reg;
            gateSamp_reg <= timer2CountGatePin;
            evSamp_reg   <= timer2CountGatePin;
            evPrev_reg   <= evSamp_reg;
            trigSamp_reg <= reloadTriggerPin;
            trigPrev_reg <= trigSamp_reg;
            capSamp_reg  <= capturePin;
            capPrev_reg  <= capSamp_reg;
         end
      end
   end

   mc_period_a: assert property (mcEn |-> ##12 mcEn)
      else $error("machine cycle enable not every 12 clocks");
   gate_sample_a: assert property (!mcEn |=> $stable(gateSamp_reg))
      else $error("gate sampled outside machine cycle");

   // Timer 2 count enable; event edges need two samples, hence osc/24 at most
   logic t2Tick, t2Ovf, trigReload, wrT2Cnt, t2Upd_reg, t2OvfEv_reg;
   always_comb begin
      unique case (t2Ctrl_reg.mode)
         T2_STOP:  t2Tick = 1'b0;
         T2_TIMER: t2Tick = mcEn && (!t2Ctrl_reg.presc24 || half24_reg);
         T2_GATED: t2Tick = mcEn && (!t2Ctrl_reg.presc24 || half24_reg) && gateSamp_reg;
         T2_EVENT: t2Tick = mcEn && evPrev_reg && !evSamp_reg;
      endcase
   end
   assign t2Ovf      = t2Tick && (t2Count_reg == CCTU_CNT_MAX);
   assign trigReload = t2Ctrl_reg.reloadEn && t2Ctrl_reg.reloadMode1 && mcEn
                       && trigPrev_reg && !trigSamp_reg;
   assign wrT2Cnt    = wrEn && (pAddr_reg == CCTU_ADDR_T2CNT);

   // Timer 2 counter and reload
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t2Count_reg <= 16'h0000;
         t2Upd_reg   <= 1'b0;
         t2OvfEv_reg <= 1'b0;
      end else begin
         t2Upd_reg   <= t2Tick;
         t2OvfEv_reg <= t2Ovf;
         if (wrT2Cnt) begin
            t2Count_reg <= hwdata[15:0];
         end else if (trigReload) begin
            t2Count_reg <= crc_reg;
         end else if (t2Ovf) begin
            t2Count_reg <= (t2Ctrl_reg.reloadEn && !t2Ctrl_reg.reloadMode1) ? crc_reg : 16'h0000;
         end else if (t2Tick) begin
            t2Count_reg <= t2Count_reg + 16'h0001;
         end
      end
   end

   t2_rate_a: assert property (t2Tick && t2Ctrl_reg.mode != T2_EVENT && t2Ctrl_reg.presc24
                               |-> mcEn && half24_reg)
      else $error("timer 2 ticked off its prescaled rate");
   gate_halt_a: assert property (t2Ctrl_reg.mode == T2_GATED && !gateSamp_reg |-> !t2Tick)
      else $error("timer 2 counted with gate low");
   event_edge_a: assert property (t2Ctrl_reg.mode == T2_EVENT && t2Tick
                                  |-> evPrev_reg && !evSamp_reg && mcEn)
      else $error("event count without falling edge");
   t2_reload0_a: assert property (t2Ovf && t2Ctrl_reg.reloadEn && !t2Ctrl_reg.reloadMode1 && !wrT2Cnt
                                  |=> t2Count_reg == $past(crc_reg) && status_reg[CCTU_STAT_T2OVF])
      else $error("timer 2 overflow reload or flag missing");
   t2_reload1_a: assert property (trigReload && !wrT2Cnt |=> t2Count_reg == $past(crc_reg))
      else $error("trigger reload missing");

   // Compare timer prescaler: tick when the low sel+1 divider bits are all ones
   logic [7:0] ctDiv_reg, ctMask;
   logic       ctTick, ctOvf, wrCtCnt, ctUpd_reg, ctOvfEv_reg;
   assign ctMask  = ~(CCTU_ONES8 << ({1'b0, ctCtrl_reg[2:0]} + CCTU_ONE4));
   assign ctTick  = ctCtrl_reg[CCTU_CT_RUN_BIT] && ((ctDiv_reg & ctMask) == ctMask);
   assign ctOvf   = ctTick && (ctCount_reg == CCTU_CNT_MAX);
   assign wrCtCnt = wrEn && (pAddr_reg == CCTU_ADDR_CTCNT);

   // Compare timer counter with auto reload
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctDiv_reg   <= 8'h00;
         ctCount_reg <= 16'h0000;
         ctUpd_reg   <= 1'b0;
         ctOvfEv_reg <= 1'b0;
      end else begin
         ctDiv_reg   <= ctDiv_reg + 8'h01;
         ctUpd_reg   <= ctTick;
         ctOvfEv_reg <= ctOvf;
         if (wrCtCnt) begin
            ctCount_reg <= hwdata[15:0];
         end else if (ctOvf) begin
            ctCount_reg <= ctReload_reg;
         end else if (ctTick) begin
            ctCount_reg <= ctCount_reg + 16'h0001;
         end
      end
   end

   ct_presc_a: assert property (ctTick |=> !ctTick)
      else $error("compare timer faster than osc/2");
   ct_reload_a: assert property (ctOvf && !wrCtCnt
                                 |=> ctCount_reg == $past(ctReload_reg) && status_reg[CCTU_STAT_CTOVF])
      else $error("compare timer reload or flag missing");

   // Per-channel mode, value, timer choice and events
   cctu_cmode_t    chMode [NCH];
   logic [15:0]    chVal  [NCH];
   logic [NCH-1:0] chUseCt, chMatch, chOvf, capEv;
   logic           wrPort;
   assign wrPort = wrEn && (pAddr_reg == CCTU_ADDR_PORTCMP);
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      if (i == 0) begin : g_crc
         // Reload/compare register cannot capture
         assign chMode[i]  = (cctu_cmode_t'(ccMode_reg[1:0]) == CM_CAPTURE) ? CM_OFF
                             : cctu_cmode_t'(ccMode_reg[1:0]);
         assign chVal[i]   = crc_reg;
         assign chUseCt[i] = 1'b0;
         assign capEv[i]   = 1'b0;
      end else if (i < CCTU_NUM_CC) begin : g_cc
         assign chMode[i]  = cctu_cmode_t'(ccMode_reg[2*i +: 2]);
         assign chVal[i]   = ccVal_reg[i-1];
         assign chUseCt[i] = 1'b0;
         assign capEv[i]   = (chMode[i] == CM_CAPTURE) && mcEn && !capSamp_reg[i-1]
                             && capPrev_reg[i-1];
      end else begin : g_cm
         assign chMode[i]  = !cmEn_reg[i-CCTU_NUM_CC] ? CM_OFF
                             : (cmSel_reg[i-CCTU_NUM_CC] ? CM_MODE1 : CM_MODE0);
         assign chVal[i]   = cmVal_reg[i-CCTU_NUM_CC];
         assign chUseCt[i] = cmSel_reg[i-CCTU_NUM_CC];
         assign capEv[i]   = 1'b0;
      end
      // Compare against the freshly updated count of the assigned timer
      assign chMatch[i] = (chMode[i] == CM_MODE0 || chMode[i] == CM_MODE1)
                          && (chUseCt[i] ? (ctUpd_reg && ctCount_reg == chVal[i])
                                         : (t2Upd_reg && t2Count_reg == chVal[i]));
      assign chOvf[i]   = chUseCt[i] ? ctOvfEv_reg : t2OvfEv_reg;

      mode0_set_a: assert property (chMode[i] == CM_MODE0 && chMatch[i] |=> compareOut[i])
         else $error("mode 0 output not set on match");
      mode0_hold_a: assert property (chMode[i] == CM_MODE0 && !chMatch[i] && !chOvf[i]
                                     |=> $stable(compareOut[i]))
         else $error("mode 0 output moved without timer event");
      mode1_move_a: assert property (chMode[i] == CM_MODE1 && chMatch[i]
                                     |=> compareOut[i] == $past(portShadow_reg[i]))
         else $error("mode 1 shadow not transferred on match");
   end

   // Capture registers; a capture event beats a software write in the same cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int k = 0; k < CCTU_NUM_CAP; k++) ccVal_reg[k] <= 16'h0000;
      end else begin
         for (int k = 0; k < CCTU_NUM_CAP; k++) begin
            if (capEv[k+1]) begin
               ccVal_reg[k] <= t2Count_reg;
            end else if (wrEn && pAddr_reg == CCTU_ADDR_CC1 + 8'(k) * CCTU_REG_STRIDE) begin
               ccVal_reg[k] <= hwdata[15:0];
            end
         end
      end
   end

   // Compare output latches per mode
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         compareOut <= '1;
      end else begin
         for (int k = 0; k < NCH; k++) begin
            unique case (chMode[k])
               CM_MODE0: begin
                  if (chMatch[k]) compareOut[k] <= 1'b1;
                  else if (chOvf[k]) compareOut[k] <= 1'b0;
               end
               CM_MODE1: if (chMatch[k]) compareOut[k] <= portShadow_reg[k];
               default:  if (wrPort) compareOut[k] <= hwdata[k];
            endcase
         end
      end
   end

   // Mode 2 port: set then clear, so clear wins if both match together
   logic setMatch, clrMatch;
   assign setMatch = mode2En_reg && t2Upd_reg && (t2Count_reg == setCmp_reg);
   assign clrMatch = mode2En_reg && t2Upd_reg && (t2Count_reg == clrCmp_reg);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         port5Out <= CCTU_PORT5_RST;
      end else if (mode2En_reg) begin
         port5Out <= (port5Out | (setMatch ? setMask_reg : 8'h00))
                     & ~(clrMatch ? clrMask_reg : 8'h00);
      end else if (wrEn && pAddr_reg == CCTU_ADDR_PORT5) begin
         port5Out <= hwdata[7:0];
      end
   end

   mode2_set_a: assert property (setMatch && !clrMatch
                                 |=> (port5Out & $past(setMask_reg)) == $past(setMask_reg))
      else $error("mode 2 set match missed masked pins");
   mode2_clr_a: assert property (clrMatch |=> (port5Out & $past(clrMask_reg)) == 8'h00)
      else $error("mode 2 clear match missed masked pins");

   // Sticky status, write one to clear; a new event wins over the clear
   logic [NCH+1:0] statSet, statClr;
   assign statSet = {chMatch | capEv, ctOvf, t2Ovf};
   assign statClr = (wrEn && pAddr_reg == CCTU_ADDR_STATUS) ? hwdata[NCH+1:0] : '0;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~statClr) | statSet;
      end
   end
   assign timer2OverflowFlag       = status_reg[CCTU_STAT_T2OVF];
   assign compareTimerOverflowFlag = status_reg[CCTU_STAT_CTOVF];
endmodule : cctu_compare_capture_timer

// ===== verif/cctu_pin_partner.sv
// Pin model: gate/count, reload trigger and capture pulses
`timescale 1ns/1ps
module cctu_pin_partner (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // Pulse request
   input  wire logic       go,
   input  wire logic [2:0] pinSel,
   input  wire logic [3:0] pulses,
   output logic            busy,
   // Pins: gate, trigger, capture 1..4
   output logic [5:0]      pinsOut
);
   logic [5:0] phase;
   logic [3:0] left;
   // Pulses of 24 clocks high, 24 low; idle low, as if pulled down
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {busy, phase, left, pinsOut} <= '0;
      end else if (go && !busy) begin
         busy <= 1'b1;
         left <= pulses;
      end else if (busy) begin
         phase <= (phase == 6'h2F) ? 6'h00 : phase + 6'h01;
         if (phase == 6'h00) pinsOut[pinSel] <= 1'b1;
         if (phase == 6'h18) pinsOut[pinSel] <= 1'b0;
         if (phase == 6'h2F) begin
            left <= left - 4'h1;
            busy <= (left != 4'h1);
         end
      end
   end
endmodule : cctu_pin_partner

// ===== verif/cctu_compare_capture_timer_tb.sv
// Self-checking bench of the compare/capture timer unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
`define WAIT_UNTIL(c) for (int k = 0; k < 2000 && !(c); k++) @(posedge clock);
module cctu_compare_capture_timer_tb;
   import cctu_pkg::*;
   logic        clock = 0, arst_n = 0, hsel = 0, hwrite = 0, go = 0;
   logic        hreadyout, hresp, t2Flag, ctFlag, busy;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2, pinSel = '0;
   logic [3:0]  pulses = '0;
   logic [5:0]  pins;
   logic [12:0] compareOut;
   logic [7:0]  port5Out;
   int          failures = 0, comparisons = 0, cycles = 0;

   // Design, bus ready looped back
   cctu_compare_capture_timer i_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .timer2CountGatePin(pins[0]), .reloadTriggerPin(pins[1]), .capturePin(pins[5:2]),
      .compareOut(compareOut), .port5Out(port5Out), .timer2OverflowFlag(t2Flag),
      .compareTimerOverflowFlag(ctFlag));
   cctu_pin_partner i_pins (.clock(clock), .arst_n(arst_n), .go(go), .pinSel(pinSel),
      .pulses(pulses), .busy(busy), .pinsOut(pins));

   // 40 MHz clock and a hang guard
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   // One AHB-Lite single transfer; read data left in rd
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask : bus

   // Ask the pin model for pulses and let them settle
   task automatic pulse(input logic [2:0] s, input logic [3:0] n);
      pinSel <= s; pulses <= n; go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      while (busy) @(posedge clock);
      repeat (36) @(posedge clock);
   endtask : pulse

   task automatic reset_state();
      `CHK("compareOut", 13'h1FFF, compareOut)
      `CHK("flags", 2'h0, {t2Flag, ctFlag})
      bus(8'h80, 1'b0, '0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("hresp", 1'b0, hresp)
   endtask : reset_state

   // Overflow reload, then mode 0 low on wrap, high on match
   task automatic reload0_mode0();
      bus(CCTU_ADDR_CRC, 1'b1, 32'h1234);
      bus(CCTU_ADDR_CC1, 1'b1, 32'h1236);
      bus(CCTU_ADDR_CCMODE, 1'b1, 32'h4);
      bus(CCTU_ADDR_T2CNT, 1'b1, 32'hFFFE);
      bus(CCTU_ADDR_T2CTRL, 1'b1, 32'h9);
      `WAIT_UNTIL(t2Flag === 1'b1)
      `CHK("t2Flag", 1'b1, t2Flag)
      repeat (2) @(posedge clock);
      `CHK("cc1 wrap", 1'b0, compareOut[1])
      bus(CCTU_ADDR_PORTCMP, 1'b1, 32'h2);
      `CHK("cc1 write", 1'b0, compareOut[1])
      `WAIT_UNTIL(compareOut[1] === 1'b1)
      bus(CCTU_ADDR_T2CNT, 1'b0, '0);
      `CHK("count at match", 32'h1236, rd)
   endtask : reload0_mode0

   // Masked set and clear of port 5
   task automatic mode2();
      bus(CCTU_ADDR_PORT5, 1'b1, 32'h0);
      `CHK("port5 direct", 8'h00, port5Out)
      bus(CCTU_ADDR_SETCMP, 1'b1, 32'h1240);
      bus(CCTU_ADDR_CLRCMP, 1'b1, 32'h1248);
      bus(CCTU_ADDR_CMP2, 1'b1, 32'h0001_030F);
      `WAIT_UNTIL(port5Out === 8'h0F)
      `CHK("port5 set", 8'h0F, port5Out)
      `WAIT_UNTIL(port5Out === 8'h0C)
      `CHK("port5 clear", 8'h0C, port5Out)
   endtask : mode2

   task automatic compare_timer();
      bus(CCTU_ADDR_CTREL, 1'b1, 32'hFFF0);
      bus(CCTU_ADDR_CTCNT, 1'b1, 32'hFFFD);
      `CHK("ctFlag idle", 1'b0, ctFlag)
      bus(CCTU_ADDR_CTCTRL, 1'b1, 32'h8);
      `WAIT_UNTIL(ctFlag === 1'b1)
      bus(CCTU_ADDR_CTCNT, 1'b0, '0);
      `CHK("ct reload", 12'hFFF, rd[15:4])
      `CHK("ctFlag", 1'b1, ctFlag)
   endtask : compare_timer

   // Event counting, then gating by the same pin
   task automatic event_gate();
      bus(CCTU_ADDR_T2CTRL, 1'b1, 32'h0);
      bus(CCTU_ADDR_T2CNT, 1'b1, 32'h0);
      bus(CCTU_ADDR_T2CTRL, 1'b1, 32'h3);
      pulse(3'h0, 4'h5);
      bus(CCTU_ADDR_T2CNT, 1'b0, '0);
      `CHK("events", 32'h5, rd)
      bus(CCTU_ADDR_T2CTRL, 1'b1, 32'h2);
      repeat (60) @(posedge clock);
      bus(CCTU_ADDR_T2CNT, 1'b0, '0);
      `CHK("gate low", 32'h5, rd)
      pulse(3'h0, 4'h1);
      bus(CCTU_ADDR_T2CNT, 1'b0, '0);
      `CHK("gate high", 1'b1, rd >= 32'h6 && rd <= 32'h8)
   endtask : event_gate

   // Trigger-pin reload, then capture into cc2
   task automatic reload1_capture();
      bus(CCTU_ADDR_T2CTRL, 1'b1, 32'h18);
      bus(CCTU_ADDR_CRC, 1'b1, 32'h0ABC);
      pulse(3'h1, 4'h1);
      bus(CCTU_ADDR_T2CNT, 1'b0, '0);
      `CHK("trigger reload", 32'h0ABC, rd)
      bus(CCTU_ADDR_CCMODE, 1'b1, 32'h30);
      bus(CCTU_ADDR_T2CNT, 1'b1, 32'h0777);
      pulse(3'h3, 4'h1);
      bus(CCTU_ADDR_CC1 + CCTU_REG_STRIDE, 1'b0, '0);
      `CHK("capture", 32'h0777, rd)
   endtask : reload1_capture

   task automatic final_report();
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      reset_state();
      reload0_mode0();
      mode2();
      compare_timer();
      event_gate();
      reload1_capture();
      final_report();
   end
endmodule : cctu_compare_capture_timer_tb
